//--- logic/watchdog_pkg.sv
// Constants, register map and types shared by the watchdog design.
package watchdog_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SERVICE = 8'ha6;
    localparam logic [7:0] ADDR_CONTROL = 8'ha7;

    // Values after reset.
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Field positions inside watchdog_control.
    localparam int PERIOD_SELECT_MSB = 7;
    localparam int PERIOD_SELECT_LSB = 5;
    localparam int IDLE_FREEZE_BIT = 4;
    localparam int OVERFLOW_FLAG_BIT = 1;
    localparam int RUNNING_INDICATOR_BIT = 0;

    // ------------------------------------------------------------
    // Service pattern and counter shape
    // ------------------------------------------------------------
    localparam logic [7:0] SERVICE_FIRST = 8'h1e;
    localparam logic [7:0] SERVICE_SECOND = 8'he1;

    localparam int PRESCALER_WIDTH = 7;
    localparam int COUNTER_WIDTH = 14;
    localparam int PERIOD_SELECT_WIDTH = 3;

    // Length of the reset pulse handed to the CPU, in clock cycles.
    localparam int RESET_PULSE_CYCLES = 1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;

    typedef struct packed {
        logic [PERIOD_SELECT_WIDTH-1:0] period_select;
        logic                           idle_freeze;
        logic                           overflow_flag;
        logic                           running_indicator;
    } control_s;

    typedef enum logic [0:0] {
        SEQ_WAIT_FIRST,
        SEQ_WAIT_SECOND
    } seq_state_e;

endpackage

//--- logic/watchdog_counter.sv
// Prescaler and time-out counter of the watchdog.
`timescale 1ns/10ps
module watchdog_counter
    import watchdog_pkg::*;
#(
    parameter int PRESC_W = PRESCALER_WIDTH,
    parameter int COUNT_W = COUNTER_WIDTH,
    parameter int SEL_W = PERIOD_SELECT_WIDTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Control
    input wire logic clear_i,
    input wire logic advance_i,
    input wire logic [SEL_W-1:0] period_select_i,
    // Status
    output logic timeout_o
);

    // The largest selection must still fit the prescaler.
    if (PRESC_W < (1 << SEL_W) - 1) begin : g_bad_width
        $error("watchdog_counter: prescaler too narrow for selector");
    end

    logic [PRESC_W-1:0] presc_q, presc_d;
    logic [COUNT_W-1:0] count_q, count_d;
    logic [PRESC_W-1:0] tick_mask;
    logic tick;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        // Period is 2**(COUNT_W + select) cycles: the counter steps
        // once every 2**select prescaler cycles. [R1] [R2]
        tick_mask = PRESC_W'((1 << period_select_i) - 1);
        tick = advance_i && ((presc_q & tick_mask) == tick_mask);
        timeout_o = tick && (count_q == {COUNT_W{1'b1}});
        presc_d = presc_q;
        count_d = count_q;
        if (clear_i) begin
            presc_d = '0; // [R14]
            count_d = '0; // [R14]
        end else if (advance_i) begin
            presc_d = presc_q + PRESC_W'(1); // [R1]
            if (tick) begin
                count_d = count_q + COUNT_W'(1); // [R1]
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            presc_q <= '0;
            count_q <= '0;
        end else begin
            presc_q <= presc_d;
            count_q <= count_d;
        end
    end

endmodule

//--- logic/watchdog_timer.sv
// Watchdog timer with special function register access.
//
// Overview of operation
// R1: 14-bit counter behind 7-bit prescaler, clock cycles.
// R2: Period select 000 gives 16K, doubling to 2048K.
// R3: Stopped after reset and power-down; arming restarts.
// R4: Time-out pulses internal CPU reset.
// R5: Writing 1EH then E1H arms the watchdog.
// R6: Control bit 0 reads running, ignores writes.
// R7: Same sequence before expiry restarts the interval.
// R8: No write between pair; reads are allowed.
// R9: Wrong sequence triggers immediate watchdog reset.
// R10: Idle-freeze bit chooses counting or freezing in idle.
// R11: Overflow flag set by time-out or bad sequence.
// R12: Control register at A7H, defined bits reset zero.
// R13: Service register at A6H, write-only.
// R14: Good sequence clears prescaler and counter.
`timescale 1ns/10ps
module watchdog_timer
    import watchdog_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Other system resets, same clock domain, level
    input wire logic other_reset_i,
    // Power state from the core, same clock domain
    input wire logic idle_i,
    input wire logic power_down_i,
    // Special function register access from the CPU core
    input wire sfr_req_s sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    // Status and reset request
    output logic running_o,
    output logic overflow_o,
    output logic cpu_reset_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    control_s ctrl_q, ctrl_d;
    seq_state_e seq_q, seq_d;
    logic [7:0] rdata_q, rdata_d;
    logic reset_pulse_q, reset_pulse_d;

    logic write_service;
    logic write_control;
    logic write_other;
    logic seq_good;
    logic seq_bad;
    logic advance;
    logic clear_count;
    logic timeout;
    logic overflow_event;
    logic [7:0] control_view;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    assign write_service = sfr_req_i.wr && (sfr_req_i.addr == ADDR_SERVICE);
    assign write_control = sfr_req_i.wr && (sfr_req_i.addr == ADDR_CONTROL);
    assign write_other = sfr_req_i.wr && !write_service;

    // The read view packs the live state; bits 3 and 2 read zero.
    always_comb begin
        control_view = CONTROL_RESET;
        control_view[PERIOD_SELECT_MSB:PERIOD_SELECT_LSB] =
            ctrl_q.period_select; // [R12]
        control_view[IDLE_FREEZE_BIT] = ctrl_q.idle_freeze; // [R12]
        control_view[OVERFLOW_FLAG_BIT] = ctrl_q.overflow_flag; // [R12]
        control_view[RUNNING_INDICATOR_BIT] =
            ctrl_q.running_indicator; // [R6]
    end

    // ------------------------------------------------------------
    // Service sequence
    // ------------------------------------------------------------
    // Reads never touch the sequence state, so they may sit between
    // the two service writes. Any write elsewhere between them counts
    // as a broken sequence, since the CPU has left the feed routine.
    always_comb begin
        seq_d = seq_q;
        seq_good = 1'b0;
        seq_bad = 1'b0;
        unique case (seq_q)
            SEQ_WAIT_FIRST: begin
                if (write_service) begin
                    if (sfr_req_i.wdata == SERVICE_FIRST) begin
                        seq_d = SEQ_WAIT_SECOND; // [R5] [R7]
                    end else begin
                        seq_bad = 1'b1; // [R9]
                    end
                end
            end
            SEQ_WAIT_SECOND: begin
                if (write_service) begin
                    seq_d = SEQ_WAIT_FIRST;
                    if (sfr_req_i.wdata == SERVICE_SECOND) begin
                        seq_good = 1'b1; // [R5] [R7]
                    end else begin
                        seq_bad = 1'b1; // [R9]
                    end
                end else if (write_other) begin
                    seq_d = SEQ_WAIT_FIRST;
                    seq_bad = 1'b1; // [R8] [R9]
                end
            end
        endcase
        // Another reset or power-down abandons a half-done sequence.
        if (other_reset_i || power_down_i) begin
            seq_d = SEQ_WAIT_FIRST;
            seq_good = 1'b0;
            seq_bad = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            seq_q <= SEQ_WAIT_FIRST;
        end else begin
            seq_q <= seq_d;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Idle with the freeze bit set holds the count where it is.
    assign advance = ctrl_q.running_indicator && !power_down_i &&
        !(idle_i && ctrl_q.idle_freeze); // [R10]
    // A good sequence restarts a full period; a stopped watchdog is
    // kept at zero so that arming always begins from a clean count.
    assign clear_count = seq_good || !ctrl_q.running_indicator; // [R14]

    watchdog_counter #(
        .PRESC_W(PRESCALER_WIDTH),
        .COUNT_W(COUNTER_WIDTH),
        .SEL_W(PERIOD_SELECT_WIDTH)
    ) u_counter (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clear_i(clear_count),
        .advance_i(advance),
        .period_select_i(ctrl_q.period_select),
        .timeout_o(timeout)
    );

    // A feed landing on the expiring cycle still saves the system.
    assign overflow_event = (timeout && !seq_good) || seq_bad;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        if (write_control) begin
            ctrl_d.period_select =
                sfr_req_i.wdata[PERIOD_SELECT_MSB:PERIOD_SELECT_LSB];
            ctrl_d.idle_freeze = sfr_req_i.wdata[IDLE_FREEZE_BIT];
            // Software may only clear the flag; writing 1 keeps it.
            if (!sfr_req_i.wdata[OVERFLOW_FLAG_BIT]) begin
                ctrl_d.overflow_flag = 1'b0; // [R11]
            end
            // The running indicator ignores writes. [R6]
        end
        if (seq_good) begin
            ctrl_d.running_indicator = 1'b1; // [R5]
        end
        // Set wins over a clear written in the same cycle.
        if (overflow_event) begin
            ctrl_d.overflow_flag = 1'b1; // [R11]
        end
        // Our own reset, other resets and power-down stop it. [R3]
        if (overflow_event || other_reset_i || power_down_i) begin
            ctrl_d.running_indicator = 1'b0; // [R3]
        end
    end

    // The flag survives the reset it requests and other resets;
    // only the power-on reset on reset_i or a software write of 0 to bit 1 clears it.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q <= control_s'(6'(CONTROL_RESET)); // [R12]
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------
    // Read data and reset pulse
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        if (sfr_req_i.rd) begin
            unique case (sfr_req_i.addr)
                ADDR_CONTROL: rdata_d = control_view;
                ADDR_SERVICE: rdata_d = READ_ZERO; // [R13]
                default: rdata_d = READ_ZERO;
            endcase
        end
        reset_pulse_d = overflow_event; // [R4] [R9]
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_q <= READ_ZERO;
            reset_pulse_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            reset_pulse_q <= reset_pulse_d;
        end
    end

    assign sfr_rdata_o = rdata_q;
    assign cpu_reset_o = reset_pulse_q;
    assign running_o = ctrl_q.running_indicator;
    assign overflow_o = ctrl_q.overflow_flag;

endmodule

//--- tb/watchdog_timer_properties.sv
// Port-level assertions for the watchdog timer.
`timescale 1ns/10ps
module watchdog_timer_properties
    import watchdog_pkg::*;
(
    // Clock and resets
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic other_reset_i,
    // Power state
    input wire logic idle_i,
    input wire logic power_down_i,
    // Register access and status
    input wire sfr_req_s sfr_req_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic running_o,
    input wire logic overflow_o,
    input wire logic cpu_reset_o
);
    // ------------------------------------------------------------
    // Decoded accesses
    // ------------------------------------------------------------
    logic svc_wr;
    logic ctl_wr;
    logic arm_wr;
    assign svc_wr = sfr_req_i.wr && sfr_req_i.addr == ADDR_SERVICE;
    assign ctl_wr = sfr_req_i.wr && sfr_req_i.addr == ADDR_CONTROL;
    assign arm_wr = svc_wr && sfr_req_i.wdata == SERVICE_SECOND;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    a_bad_byte: assert property (
        svc_wr && sfr_req_i.wdata != SERVICE_FIRST && !arm_wr
        |=> cpu_reset_o && overflow_o && !running_o)
        else $error("bad service byte gave no reset");
    a_pulse_stops: assert property (
        cpu_reset_o |-> overflow_o && !running_o)
        else $error("reset pulse without flag or with running");
    a_arm_cause: assert property (
        $rose(running_o) |-> $past(arm_wr))
        else $error("watchdog started without a second service byte");
    a_status_read: assert property (
        sfr_req_i.rd && sfr_req_i.addr == ADDR_CONTROL
        |=> sfr_rdata_o[1:0] == {$past(overflow_o), $past(running_o)})
        else $error("control read does not match status");
    a_service_read: assert property (
        sfr_req_i.rd && sfr_req_i.addr == ADDR_SERVICE
        |=> sfr_rdata_o == READ_ZERO)
        else $error("service register returned data");
    a_power_stop: assert property (
        power_down_i |=> !running_o)
        else $error("running during power-down");
    a_other_stop: assert property (
        other_reset_i |=> !running_o)
        else $error("running after system reset");
    a_flag_hold: assert property (
        overflow_o && !ctl_wr |=> overflow_o)
        else $error("overflow flag lost without a write");
    a_flag_cause: assert property (
        $rose(overflow_o) |-> cpu_reset_o)
        else $error("overflow flag set without reset pulse");
endmodule

//--- tb/cpu_core_model.sv
// Behavioural CPU core issuing register accesses to the watchdog.
`timescale 1ns/10ps
module cpu_core_model
    import watchdog_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Register access
    input wire logic [7:0] sfr_rdata_i,
    output sfr_req_s sfr_req_o
);
    initial sfr_req_o = '0;

    // A released bus shows inverted values so stale data cannot match.
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [7:0] d);
        sfr_req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_i);
        sfr_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(posedge clk_i);
    endtask

    task automatic write(input logic [7:0] a, input logic [7:0] d);
        access(1'b1, a, d);
    endtask

    task automatic read(input logic [7:0] a, output logic [7:0] d);
        access(1'b0, a, 8'h00);
        d = sfr_rdata_i;
    endtask

    // Arming and feeding share one pair with no write in between.
    task automatic service();
        write(ADDR_SERVICE, SERVICE_FIRST);
        write(ADDR_SERVICE, SERVICE_SECOND);
    endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the watchdog timer.
`timescale 1ns/10ps
module tb_top
    import watchdog_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic other_reset_i = 1'b0;
    logic idle_i = 1'b0;
    logic power_down_i = 1'b0;
    sfr_req_s sfr_req;
    logic [7:0] sfr_rdata_o;
    logic running_o;
    logic overflow_o;
    logic cpu_reset_o;
    logic [7:0] d;
    int n;
    int errors = 0;
    int total_checks = 0;

    watchdog_timer u_watchdog_timer(.clk_i(clk_i), .reset_i(reset_i),
        .other_reset_i(other_reset_i), .idle_i(idle_i),
        .power_down_i(power_down_i), .sfr_req_i(sfr_req),
        .sfr_rdata_o(sfr_rdata_o), .running_o(running_o),
        .overflow_o(overflow_o), .cpu_reset_o(cpu_reset_o));
    cpu_core_model u_cpu_core_model(.clk_i(clk_i),
        .sfr_rdata_i(sfr_rdata_o), .sfr_req_o(sfr_req));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Samples on the falling edge, where the pulse is settled, then
    // hands back on a rising edge so that stimulus stays aligned.
    task automatic wait_reset(input int lim);
        n = 1;
        while (cpu_reset_o !== 1'b1 && n < lim) begin
            @(negedge clk_i);
            n++;
        end
        if (cpu_reset_o !== 1'b1) begin
            errors++;
            summarize();
        end
        @(posedge clk_i);
    endtask

    // The reset pulse stands one cycle and ends before the write
    // task returns, so it is watched while the write is under way.
    task automatic wr_pulse(input logic [7:0] a, input logic [7:0] v);
        logic seen;
        seen = 1'b0;
        fork
            u_cpu_core_model.write(a, v);
            repeat (2) begin
                @(negedge clk_i);
                seen = seen | cpu_reset_o;
            end
        join
        chk(8'(seen), 8'h01);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        u_cpu_core_model.read(a, d);
        chk(d, exp);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_fields();
        rd_chk(ADDR_CONTROL, CONTROL_RESET);
        rd_chk(ADDR_SERVICE, READ_ZERO);
        u_cpu_core_model.write(ADDR_SERVICE, SERVICE_FIRST);
        rd_chk(ADDR_CONTROL, 8'h00);
        u_cpu_core_model.write(ADDR_SERVICE, SERVICE_SECOND);
        rd_chk(ADDR_CONTROL, 8'h01);
        u_cpu_core_model.write(ADDR_CONTROL, 8'hff);
        rd_chk(ADDR_CONTROL, 8'hf1);
        u_cpu_core_model.write(ADDR_CONTROL, 8'h00);
    endtask

    // Shortest period is 16K cycles from the edge that takes the pair.
    task automatic t_timeout();
        u_cpu_core_model.service();
        wait_reset(20000);
        chk(8'(n >= 16384 && n <= 16386), 8'h01);
        rd_chk(ADDR_CONTROL, 8'h02);
        u_cpu_core_model.write(ADDR_CONTROL, 8'h00);
        rd_chk(ADDR_CONTROL, 8'h00);
    endtask

    // Select 001 doubles the period to 32K: a feed after 20K cycles
    // must carry the watchdog past the unfed expiry point.
    task automatic t_feed_stop();
        u_cpu_core_model.write(ADDR_CONTROL, 8'h20);
        u_cpu_core_model.service();
        repeat (20000) @(posedge clk_i);
        u_cpu_core_model.service();
        repeat (20000) @(posedge clk_i);
        rd_chk(ADDR_CONTROL, 8'h21);
        power_down_i <= 1'b1;
        @(posedge clk_i);
        power_down_i <= 1'b0;
        rd_chk(ADDR_CONTROL, 8'h20);
        u_cpu_core_model.service();
        other_reset_i <= 1'b1;
        @(posedge clk_i);
        other_reset_i <= 1'b0;
        rd_chk(ADDR_CONTROL, 8'h20);
    endtask

    task automatic t_bad();
        u_cpu_core_model.write(ADDR_SERVICE, SERVICE_FIRST);
        wr_pulse(ADDR_CONTROL, 8'h00);
        rd_chk(ADDR_CONTROL, 8'h02);
        wr_pulse(ADDR_SERVICE, 8'h55);
        u_cpu_core_model.write(ADDR_CONTROL, 8'h00);
    endtask

    // A power-on reset in mid-run stops the watchdog and drops the flag.
    task automatic t_reset();
        wr_pulse(ADDR_SERVICE, 8'h55);
        u_cpu_core_model.service();
        rd_chk(ADDR_CONTROL, 8'h03);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        rd_chk(ADDR_CONTROL, CONTROL_RESET);
    endtask

    task automatic t_idle();
        u_cpu_core_model.write(ADDR_CONTROL, 8'h10);
        u_cpu_core_model.service();
        idle_i <= 1'b1;
        repeat (17000) @(posedge clk_i);
        rd_chk(ADDR_CONTROL, 8'h11);
        u_cpu_core_model.write(ADDR_CONTROL, 8'h00);
        wait_reset(17000);
        rd_chk(ADDR_CONTROL, 8'h02);
        idle_i <= 1'b0;
        u_cpu_core_model.write(ADDR_CONTROL, 8'h00);
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        t_fields();
        t_timeout();
        t_feed_stop();
        t_bad();
        t_idle();
        t_reset();
        summarize();
    end
endmodule

bind watchdog_timer watchdog_timer_properties u_props(.clk_i(clk_i),
    .reset_i(reset_i), .other_reset_i(other_reset_i), .idle_i(idle_i),
    .power_down_i(power_down_i), .sfr_req_i(sfr_req_i),
    .sfr_rdata_o(sfr_rdata_o), .running_o(running_o),
    .overflow_o(overflow_o), .cpu_reset_o(cpu_reset_o));
